// >>> core/mteu_defines.vh
// Constants of the meter token execution unit.
`ifndef MTEU_DEFINES_VH
`define MTEU_DEFINES_VH
`define MTEU_ADDR_CTRL 12'h000
`define MTEU_ADDR_TOKLO 12'h004
`define MTEU_ADDR_TOKHI 12'h008
`define MTEU_ADDR_STATUS 12'h00C
`define MTEU_ADDR_CREDIT0 12'h010
`define MTEU_ADDR_CREDIT1 12'h014
`define MTEU_ADDR_CREDIT2 12'h018
`define MTEU_ADDR_CREDIT3 12'h01C
`define MTEU_ADDR_PLIMIT 12'h020
`define MTEU_ADDR_ULIMIT 12'h024
`define MTEU_ADDR_KEYLO 12'h028
`define MTEU_ADDR_KEYHI 12'h02C
`define MTEU_ADDR_KEYATTR 12'h030
`define MTEU_ADDR_IDENT 12'h034
`define MTEU_ADDR_TESTS 12'h038
`define MTEU_ADDR_TAMPER 12'h03C
`define MTEU_ADDR_KEYTIME 12'h040
`define MTEU_ADDR_RESULT1 12'h044
`define MTEU_CLASS_CREDIT 2'h0
`define MTEU_CLASS_MGMT 2'h2
`define MTEU_CLASS_RSVD 2'h3
`define MTEU_VAR_PLIMIT 4'h0
`define MTEU_VAR_CLRCRED 4'h1
`define MTEU_VAR_KC1 4'h3
`define MTEU_VAR_KC2 4'h4
`define MTEU_VAR_TAMPER 4'h5
`define MTEU_VAR_ULIMIT 4'h6
`define MTEU_VAR_KC3 4'h8
`define MTEU_VAR_KC4 4'h9
`define MTEU_RES_NONE 4'h0
`define MTEU_RES_ACCEPT 4'h1
`define MTEU_RES_REJECT 4'h2
`define MTEU_RES_OLD 4'h3
`define MTEU_RES_USED 4'h4
`define MTEU_RES_KEYEXP 4'h5
`define MTEU_RES_DEFKEY 4'h6
`define MTEU_RES_FUNC 4'h7
`define MTEU_RES_KCDONE 4'h8
`define MTEU_RES_OVERFLOW 4'h9
`define MTEU_RES_KC1 4'hA
`define MTEU_RES_KC2 4'hB
`define MTEU_RES_KC3 4'hC
`define MTEU_RES_KC4 4'hD
`define MTEU_RES_MFR 4'hE
`define MTEU_VAL_OK 3'h0
`define MTEU_VAL_OLD 3'h1
`define MTEU_VAL_USED 3'h2
`define MTEU_VAL_KEYEXP 3'h3
`define MTEU_VAL_DEFKEY 3'h4
`define MTEU_KEYTIME_S 420
`define MTEU_CLK_HZ 40'h000BEBC200
`define MTEU_TEST_STEP_CYC 16
`endif

// >>> core/mteu_test_seq.v
// Steps through selected test outputs in fixed order.
`timescale 1ns/10ps
`include "mteu_defines.vh"
module mteu_test_seq #(
    parameter NTEST = 8,
    parameter STEP = `MTEU_TEST_STEP_CYC
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire start,
    input wire [NTEST-1:0] selMask,
    output wire busy,
    output reg [NTEST-1:0] testStrobe
);
    reg [NTEST-1:0] pend_r;
    reg [7:0] gap_r;
    integer i;
    reg found;
    reg [NTEST-1:0] pick;
    // Lowest pending bit is started first.
    always @* begin
        pick = {NTEST{1'b0}};
        found = 1'b0;
        for (i = 0; i < NTEST; i = i + 1) begin
            if (pend_r[i] && !found) begin
                pick[i] = 1'b1;
                found = 1'b1;
            end
        end
    end
    assign busy = |pend_r;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_r <= {NTEST{1'b0}};
            gap_r <= 8'h00;
            testStrobe <= {NTEST{1'b0}};
        end else begin
            testStrobe <= {NTEST{1'b0}};
            if (start) begin
                pend_r <= selMask;
                gap_r <= 8'h00;
            end else if (gap_r != 8'h00) begin
                gap_r <= gap_r - 8'h01;
            end else if (found) begin
                testStrobe <= pick;
                pend_r <= pend_r & ~pick;
                gap_r <= STEP[7:0];
            end
        end
    end
endmodule // mteu_test_seq

// >>> core/mteu_key_asm.v
// Collects key change parts and swaps the single active key.
`timescale 1ns/10ps
`include "mteu_defines.vh"
module mteu_key_asm #(
    parameter [39:0] TOUT_CYC = `MTEU_KEYTIME_S * `MTEU_CLK_HZ
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire partValid,
    input wire [1:0] partIdx,
    input wire [31:0] partData,
    output reg [63:0] active_decryption_key,
    output reg [63:0] keyAttr,
    output reg done,
    output wire [3:0] havePart,
    output wire pending
);
    reg [31:0] part_r [0:3];
    reg [3:0] have_r;
    reg [39:0] timer_r;
    wire [3:0] haveNxt;
    assign haveNxt = have_r | (4'h1 << partIdx);
    assign havePart = have_r;
    assign pending = |have_r;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            have_r <= 4'h0;
            timer_r <= 40'h0000000000;
            done <= 1'b0;
            active_decryption_key <= 64'h0000000000000000;
            keyAttr <= 64'h0000000000000000;
            part_r[0] <= 32'h00000000;
            part_r[1] <= 32'h00000000;
            part_r[2] <= 32'h00000000;
            part_r[3] <= 32'h00000000;
        end else begin
            done <= 1'b0;
            if (partValid) begin
                part_r[partIdx] <= partData;
                if (have_r == 4'h0)
                    timer_r <= 40'h0000000000;
                if (haveNxt == 4'hF) begin
                    // Key and attributes are swapped together on the same clock edge.
                    active_decryption_key <= {part_r[1], part_r[0]};
                    keyAttr <= {part_r[3], part_r[2]};
                    if (partIdx == 2'h0)
                        active_decryption_key[31:0] <= partData;
                    if (partIdx == 2'h1)
                        active_decryption_key[63:32] <= partData;
                    if (partIdx == 2'h2)
                        keyAttr[31:0] <= partData;
                    if (partIdx == 2'h3)
                        keyAttr[63:32] <= partData;
                    have_r <= 4'h0;
                    done <= 1'b1;
                end else begin
                    have_r <= haveNxt;
                end
            end else if (have_r != 4'h0) begin
                if (timer_r >= TOUT_CYC - 40'h0000000001) begin
                    have_r <= 4'h0;
                    timer_r <= 40'h0000000000;
                end else begin
                    timer_r <= timer_r + 40'h0000000001;
                end
            end
        end
    end
endmodule // mteu_key_asm

// >>> core/mteu_exec.v
// Token execution unit with APB register access.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "mteu_defines.vh"
module mteu_exec #(
    parameter [39:0] KEY_TOUT_CYC = `MTEU_KEYTIME_S * `MTEU_CLK_HZ,
    parameter NTEST = 8,
    parameter [NTEST-1:0] TEST_SUPPORTED = 8'h0F,
    parameter [15:0] MFR_CODE = 16'h0042, // Arbitrary value.
    parameter [31:0] DRN_VALUE = 32'h12345678, // Arbitrary value.
    parameter [7:0] EA_VALUE = 8'h07 // Arbitrary value.
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    output reg [3:0] resultCode,
    output reg [1:0] resultPort,
    output reg resultValid,
    output wire [NTEST-1:0] testStrobe,
    output reg propStrobe,
    output reg [31:0] propData,
    output reg tamperCancel,
    output reg tamperFlag
);
    // Minutes of cycles at full rate need a 40-bit count.
    localparam [39:0] KTO = KEY_TOUT_CYC;
    reg [31:0] tokLo_r;
    reg [31:0] tokHi_r;
    reg [1:0] srcPort_r;
    reg [2:0] valRes_r;
    reg auth_r;
    reg go_r;
    reg [31:0] credit_r [0:3];
    reg [31:0] pLimit_r;
    reg [31:0] uLimit_r;
    reg [3:0] status_r;
    reg showId_r;
    reg kcValid;
    reg [1:0] kcIdx;
    reg seqStart;
    reg [NTEST-1:0] seqMask;
    wire [63:0] keyVal;
    wire [63:0] keyAttr;
    wire kcDone;
    wire kcPending;
    wire [3:0] kcHave;
    wire seqBusy;
    wire apbWr;
    wire apbRd;
    wire [1:0] tokClass;
    wire [3:0] token_variant_field;
    wire [1:0] credSel;
    wire [31:0] amount;
    wire [32:0] credSum;
    wire [NTEST-1:0] ctrlField;
    wire [15:0] manufacturer_code;
    wire defaultKey;
    assign apbWr = psel & penable & pwrite;
    assign apbRd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign tokClass = tokHi_r[31:30];
    assign token_variant_field = tokHi_r[29:26];
    assign credSel = token_variant_field[1:0];
    assign amount = tokLo_r;
    assign ctrlField = tokLo_r[NTEST-1:0];
    assign manufacturer_code = tokLo_r[31:16];
    assign credSum = {1'b0, credit_r[credSel]} + {1'b0, amount};
    assign defaultKey = (keyAttr[7:4] == 4'h0);

    // Maps a key part variant to its slot.
    function [1:0] kcSlot;
        input [3:0] v;
        begin
            case (v)
                `MTEU_VAR_KC1: kcSlot = 2'h0;
                `MTEU_VAR_KC2: kcSlot = 2'h1;
                `MTEU_VAR_KC3: kcSlot = 2'h2;
                default: kcSlot = 2'h3;
            endcase
        end
    endfunction

    function isKeyVar;
        input [3:0] v;
        begin
            isKeyVar = (v == `MTEU_VAR_KC1) || (v == `MTEU_VAR_KC2) ||
                (v == `MTEU_VAR_KC3) || (v == `MTEU_VAR_KC4);
        end
    endfunction

    // Maps a validation status to its result code.
    function [3:0] valCode;
        input [2:0] s;
        begin
            case (s)
                `MTEU_VAL_OLD: valCode = `MTEU_RES_OLD;
                `MTEU_VAL_USED: valCode = `MTEU_RES_USED;
                `MTEU_VAL_KEYEXP: valCode = `MTEU_RES_KEYEXP;
                `MTEU_VAL_DEFKEY: valCode = `MTEU_RES_DEFKEY;
                default: valCode = `MTEU_RES_REJECT;
            endcase
        end
    endfunction

    mteu_key_asm #(
        .TOUT_CYC(KTO)
    ) u_key (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .partValid(kcValid),
        .partIdx(kcIdx),
        .partData(tokLo_r),
        .active_decryption_key(keyVal),
        .keyAttr(keyAttr),
        .done(kcDone),
        .havePart(kcHave),
        .pending(kcPending)
    );

    mteu_test_seq #(
        .NTEST(NTEST)
    ) u_seq (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(seqStart),
        .selMask(seqMask),
        .busy(seqBusy),
        .testStrobe(testStrobe)
    );

    // Decodes the latched token into the key part and test start strobes.
    always @* begin
        kcValid = 1'b0;
        kcIdx = kcSlot(token_variant_field);
        seqStart = 1'b0;
        seqMask = ctrlField & TEST_SUPPORTED;
        if (go_r && auth_r && valRes_r == `MTEU_VAL_OK &&
            tokClass == `MTEU_CLASS_MGMT && isKeyVar(token_variant_field))
            kcValid = 1'b1;
        if (go_r && auth_r && valRes_r == `MTEU_VAL_OK &&
            tokClass == 2'h1 && token_variant_field == 4'h0 &&
            (ctrlField[NTEST-1:1] & ~TEST_SUPPORTED[NTEST-1:1]) ==
            {(NTEST-1){1'b0}})
            seqStart = 1'b1;
        if (go_r && auth_r && valRes_r == `MTEU_VAL_OK && tokClass == 2'h1 &&
            token_variant_field >= 4'h6 && manufacturer_code == MFR_CODE)
            seqStart = 1'b1;
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            tokLo_r <= 32'h00000000;
            tokHi_r <= 32'h00000000;
            srcPort_r <= 2'h0;
            valRes_r <= 3'h0;
            auth_r <= 1'b0;
            go_r <= 1'b0;
            credit_r[0] <= 32'h00000000;
            credit_r[1] <= 32'h00000000;
            credit_r[2] <= 32'h00000000;
            credit_r[3] <= 32'h00000000;
            pLimit_r <= 32'h00000000;
            uLimit_r <= 32'h00000000;
            status_r <= `MTEU_RES_NONE;
            showId_r <= 1'b0;
            resultCode <= `MTEU_RES_NONE;
            resultPort <= 2'h0;
            resultValid <= 1'b0;
            propStrobe <= 1'b0;
            propData <= 32'h00000000;
            tamperCancel <= 1'b0;
            tamperFlag <= 1'b0;
        end else begin
            go_r <= 1'b0;
            resultValid <= 1'b0;
            propStrobe <= 1'b0;
            tamperCancel <= 1'b0;
            if (apbWr) begin
                case (paddr)
                    `MTEU_ADDR_TOKLO: tokLo_r <= pwdata;
                    `MTEU_ADDR_TOKHI: tokHi_r <= pwdata;
                    `MTEU_ADDR_CTRL: begin
                        // Bit 0 executes; bits 2:1 tag the entry port.
                        go_r <= pwdata[0];
                        srcPort_r <= pwdata[2:1];
                        auth_r <= pwdata[3];
                        valRes_r <= pwdata[6:4];
                        showId_r <= pwdata[8];
                    end
                    `MTEU_ADDR_TAMPER: tamperFlag <= pwdata[0];
                    default: begin
                    end
                endcase
            end
            if (go_r) begin
                resultValid <= 1'b1;
                resultPort <= srcPort_r;
                if (!auth_r) begin
                    resultCode <= `MTEU_RES_REJECT;
                end else if (valRes_r != `MTEU_VAL_OK) begin
                    resultCode <= valCode(valRes_r);
                end else if (tokClass == `MTEU_CLASS_CREDIT) begin
                    if (defaultKey) begin
                        resultCode <= `MTEU_RES_DEFKEY;
                    end else if (credSum[32]) begin
                        resultCode <= `MTEU_RES_OVERFLOW;
                    end else begin
                        credit_r[credSel] <= credSum[31:0];
                        resultCode <= `MTEU_RES_ACCEPT;
                    end
                end else if (tokClass == 2'h1) begin
                    if (token_variant_field >= 4'h6) begin
                        resultCode <= (manufacturer_code == MFR_CODE) ?
                            `MTEU_RES_ACCEPT : `MTEU_RES_REJECT;
                    end else if (token_variant_field == 4'h0 && seqStart) begin
                        resultCode <= `MTEU_RES_ACCEPT;
                    end else begin
                        resultCode <= `MTEU_RES_FUNC;
                    end
                end else if (tokClass == `MTEU_CLASS_MGMT) begin
                    if (token_variant_field == `MTEU_VAR_PLIMIT) begin
                        pLimit_r <= tokLo_r;
                        resultCode <= `MTEU_RES_ACCEPT;
                    end else if (token_variant_field == `MTEU_VAR_CLRCRED) begin
                        credit_r[tokLo_r[1:0]] <= 32'h00000000;
                        resultCode <= `MTEU_RES_ACCEPT;
                    end else if (token_variant_field == `MTEU_VAR_TAMPER) begin
                        tamperFlag <= 1'b0;
                        tamperCancel <= 1'b1;
                        resultCode <= `MTEU_RES_ACCEPT;
                    end else if (token_variant_field == `MTEU_VAR_ULIMIT) begin
                        uLimit_r <= tokLo_r;
                        resultCode <= `MTEU_RES_ACCEPT;
                    end else if (isKeyVar(token_variant_field)) begin
                        if ((kcHave | (4'h1 << kcIdx)) == 4'hF)
                            resultCode <= `MTEU_RES_KCDONE;
                        else
                            resultCode <= `MTEU_RES_KC1 +
                                {2'h0, kcIdx};
                    end else if (token_variant_field >= 4'hC) begin
                        propStrobe <= 1'b1;
                        propData <= tokLo_r;
                        resultCode <= `MTEU_RES_MFR;
                    end else begin
                        resultCode <= `MTEU_RES_REJECT;
                    end
                end else begin
                    resultCode <= `MTEU_RES_REJECT;
                end
            end
            if (go_r)
                status_r <= `MTEU_RES_NONE;
        end
    end

    // Read mux; unmapped addresses return zero.
    always @* begin
        prdata = 32'h00000000;
        if (apbRd) begin
            case (paddr)
                `MTEU_ADDR_TOKLO: prdata = tokLo_r;
                `MTEU_ADDR_TOKHI: prdata = tokHi_r;
                `MTEU_ADDR_STATUS: prdata = {20'h00000, kcHave, seqBusy,
                    kcPending, resultPort, resultCode};
                `MTEU_ADDR_CREDIT0: prdata = credit_r[0];
                `MTEU_ADDR_CREDIT1: prdata = credit_r[1];
                `MTEU_ADDR_CREDIT2: prdata = credit_r[2];
                `MTEU_ADDR_CREDIT3: prdata = credit_r[3];
                `MTEU_ADDR_PLIMIT: prdata = pLimit_r;
                `MTEU_ADDR_ULIMIT: prdata = uLimit_r;
                `MTEU_ADDR_KEYLO: prdata = keyVal[31:0];
                `MTEU_ADDR_KEYHI: prdata = keyVal[63:32];
                `MTEU_ADDR_KEYATTR: prdata = keyAttr[31:0];
                `MTEU_ADDR_IDENT: prdata = showId_r ? DRN_VALUE :
                    {24'h000000, EA_VALUE};
                `MTEU_ADDR_TESTS: prdata = {24'h000000, TEST_SUPPORTED};
                `MTEU_ADDR_TAMPER: prdata = {31'h00000000, tamperFlag};
                `MTEU_ADDR_RESULT1: prdata = {28'h0000000, status_r};
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule // mteu_exec

// >>> dv/mteu_checker.sv
// Port assertions for the meter token execution unit.
`timescale 1ns/10ps
`include "mteu_defines.vh"
module mteu_checker #(
    parameter NTEST = 8,
    parameter [NTEST-1:0] TEST_SUPPORTED = 8'h0F
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] resultCode,
    input wire [1:0] resultPort,
    input wire resultValid,
    input wire [NTEST-1:0] testStrobe,
    input wire propStrobe,
    input wire tamperCancel,
    input wire tamperFlag
);
    reg [1:0] tokClass_r;
    wire wrEdge;
    wire execGo;
    assign wrEdge = psel && penable && pwrite;
    assign execGo = wrEdge && paddr == `MTEU_ADDR_CTRL && pwdata[0];
    // Keeps the class of the token staged for the next execute.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            tokClass_r <= 2'h0;
        end else if (wrEdge && paddr == `MTEU_ADDR_TOKHI) begin
            tokClass_r <= pwdata[31:30];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence s_exec;
        execGo;
    endsequence
    sequence s_cleanExec;
        execGo && pwdata[3] && pwdata[6:4] == 3'h0;
    endsequence
    property p_resLat;
        s_exec |-> ##2 resultValid;
    endproperty
    a_resLat: assert property (p_resLat)
        else $error("no result after execute");
    property p_resPort;
        s_exec |-> ##2 resultPort == $past(pwdata[2:1], 2);
    endproperty
    a_resPort: assert property (p_resPort)
        else $error("result port differs from entry port");
    property p_resPulse;
        resultValid |=> !resultValid;
    endproperty
    a_resPulse: assert property (p_resPulse)
        else $error("result valid longer than one cycle");
    property p_resHold;
        !resultValid |-> $stable(resultCode) && $stable(resultPort);
    endproperty
    a_resHold: assert property (p_resHold)
        else $error("result changed without a result pulse");
    property p_rsvd;
        s_cleanExec ##0 tokClass_r == `MTEU_CLASS_RSVD
            |-> ##2 resultCode == `MTEU_RES_REJECT;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved class not rejected");
    property p_oneTest;
        $onehot0(testStrobe);
    endproperty
    a_oneTest: assert property (p_oneTest)
        else $error("two tests started together");
    property p_testGap;
        |testStrobe |=> (testStrobe == 0) [*8];
    endproperty
    a_testGap: assert property (p_testGap)
        else $error("tests started too close");
    property p_testSup;
        (testStrobe & ~TEST_SUPPORTED) == 0;
    endproperty
    a_testSup: assert property (p_testSup)
        else $error("unsupported test started");
    property p_tamper;
        tamperCancel |-> ##[0:1] !tamperFlag;
    endproperty
    a_tamper: assert property (p_tamper)
        else $error("tamper flag kept after clear");
endmodule // mteu_checker

// >>> dv/mteu_ui_model.sv
// Far-side model of the display and load functions.
`timescale 1ns/10ps
module mteu_ui_model #(
    parameter NTEST = 8
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire clrLog,
    input wire [NTEST-1:0] testStrobe,
    input wire propStrobe,
    input wire tamperCancel,
    output reg [NTEST-1:0] seenMask,
    output reg [7:0] stbCnt,
    output reg ordOk,
    output reg [7:0] evtCnt
);
    // A test must rank above every test already started in the run.
    always @(posedge clk_sys) begin
        if (sys_rst || clrLog) begin
            seenMask <= {NTEST{1'b0}};
            stbCnt <= 8'h00;
            ordOk <= 1'b1;
        end else if (|testStrobe) begin
            seenMask <= seenMask | testStrobe;
            stbCnt <= stbCnt + 8'h01;
            if (testStrobe <= seenMask) begin
                ordOk <= 1'b0;
            end
        end
    end
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            evtCnt <= 8'h00;
        end else if (propStrobe || tamperCancel) begin
            evtCnt <= evtCnt + 8'h01;
        end
    end
endmodule // mteu_ui_model

// >>> dv/tb_meter_token_execution_unit.sv
// Self-checking bench for the meter token execution unit.
`timescale 1ns/10ps
`include "mteu_defines.vh"
module tb_meter_token_execution_unit;
    localparam NTEST = 8;
    localparam [7:0] TSUP = 8'h0F;
    localparam [15:0] MFRC = 16'h00A5; // Arbitrary value.
    localparam [31:0] DRNV = 32'h3C5A0F96; // Arbitrary value.
    localparam [7:0] EAV = 8'h2B; // Arbitrary value.
    localparam [8:0] GO = 9'h009;
    localparam [29:0] RSVD = {6'h22, 6'h27, 6'h2A, 6'h2B, 6'h3C};
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg clrLog = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [31:0] rdat;
    wire pready, pslverr, resultValid, propStrobe, tamperCancel;
    wire tamperFlag, ordOk;
    wire [31:0] prdata, propData;
    wire [3:0] resultCode;
    wire [1:0] resultPort;
    wire [7:0] testStrobe, seenMask, stbCnt, evtCnt;
    integer error_cnt = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    integer i;
    mteu_exec #(.KEY_TOUT_CYC(150), .NTEST(NTEST), .TEST_SUPPORTED(TSUP),
        .MFR_CODE(MFRC), .DRN_VALUE(DRNV), .EA_VALUE(EAV)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .resultCode(resultCode),
        .resultPort(resultPort), .resultValid(resultValid),
        .testStrobe(testStrobe), .propStrobe(propStrobe),
        .propData(propData), .tamperCancel(tamperCancel),
        .tamperFlag(tamperFlag));
    mteu_ui_model #(.NTEST(NTEST)) ui (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .clrLog(clrLog), .testStrobe(testStrobe),
        .propStrobe(propStrobe), .tamperCancel(tamperCancel),
        .seenMask(seenMask), .stbCnt(stbCnt), .ordOk(ordOk),
        .evtCnt(evtCnt));
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    task conclude;
        begin
            if (error_cnt == 0 && cmp_count > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1) @(posedge clk_sys);
            rdat = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check(rdat, exp);
        end
    endtask
    task tok(input [5:0] cv, input [31:0] lo, input [8:0] ctl,
        input [3:0] exp);
        begin
            wr(`MTEU_ADDR_TOKHI, {cv, 26'h0});
            wr(`MTEU_ADDR_TOKLO, lo);
            wr(`MTEU_ADDR_CTRL, {23'h0, ctl});
            repeat (3) @(posedge clk_sys);
            if (exp != 4'hF) check({28'h0, resultCode}, {28'h0, exp});
        end
    endtask
    task kc(input [3:0] v, input [3:0] exp);
        tok({2'h2, v}, {8{v}}, GO, exp);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`MTEU_ADDR_STATUS, 32'h0);
        wr(12'hFF0, 32'hFFFFFFFF);
        rd(12'hFF0, 32'h0);
        wr(`MTEU_ADDR_CTRL, 32'h100);
        rd(`MTEU_ADDR_IDENT, DRNV);
        wr(`MTEU_ADDR_CTRL, 32'h0);
        rd(`MTEU_ADDR_IDENT, {24'h0, EAV});
        tok(6'h00, 32'h10, GO, `MTEU_RES_DEFKEY);
        rd(`MTEU_ADDR_CREDIT0, 32'h0);
        tok(6'h20, 32'h5, 9'h001, `MTEU_RES_REJECT);
        for (i = 1; i < 5; i = i + 1) begin
            tok(6'h20, 32'h5, {2'h0, i[2:0], 4'h9}, i[3:0] + 4'h2);
        end
        rd(`MTEU_ADDR_PLIMIT, 32'h0);
        // Key parts out of order, with foreign and repeated tokens between.
        kc(4'h9, `MTEU_RES_KC4);
        tok(6'h30, 32'h1, GO, `MTEU_RES_REJECT);
        kc(4'h3, `MTEU_RES_KC1);
        kc(4'h3, `MTEU_RES_KC1);
        tok(6'h22, 32'h1, GO, `MTEU_RES_REJECT);
        kc(4'h8, `MTEU_RES_KC3);
        rd(`MTEU_ADDR_KEYLO, 32'h0);
        kc(4'h4, `MTEU_RES_KCDONE);
        rd(`MTEU_ADDR_KEYLO, 32'h33333333);
        rd(`MTEU_ADDR_KEYHI, 32'h44444444);
        rd(`MTEU_ADDR_KEYATTR, 32'h88888888);
        rd(`MTEU_ADDR_STATUS, 32'h8);
        kc(4'h3, `MTEU_RES_KC1);
        rd(`MTEU_ADDR_STATUS, 32'h14A);
        repeat (160) @(posedge clk_sys);
        rd(`MTEU_ADDR_STATUS, 32'h00A);
        tok(6'h01, 32'h100, GO | 9'h004, `MTEU_RES_ACCEPT);
        check({30'h0, resultPort}, 32'h2);
        rd(`MTEU_ADDR_CREDIT1, 32'h100);
        rd(`MTEU_ADDR_CREDIT0, 32'h0);
        tok(6'h01, 32'hFFFFFF80, GO, `MTEU_RES_OVERFLOW);
        rd(`MTEU_ADDR_CREDIT1, 32'h100);
        tok(6'h21, 32'h1, GO, `MTEU_RES_ACCEPT);
        rd(`MTEU_ADDR_CREDIT1, 32'h0);
        tok(6'h20, 32'h1234, GO, `MTEU_RES_ACCEPT);
        rd(`MTEU_ADDR_PLIMIT, 32'h1234);
        tok(6'h26, 32'h567, GO, `MTEU_RES_ACCEPT);
        rd(`MTEU_ADDR_ULIMIT, 32'h567);
        wr(`MTEU_ADDR_TAMPER, 32'h1);
        @(posedge clk_sys);
        check({31'h0, tamperFlag}, 32'h1);
        tok(6'h25, 32'h0, GO, `MTEU_RES_ACCEPT);
        check({31'h0, tamperFlag}, 32'h0);
        check({24'h0, evtCnt}, 32'h1);
        for (i = 0; i < 5; i = i + 1) begin
            tok(RSVD[i*6 +: 6], 32'h1, GO, `MTEU_RES_REJECT);
        end
        tok(6'h2C, 32'hCAFE0001, GO, `MTEU_RES_MFR);
        check(propData, 32'hCAFE0001);
        check({24'h0, evtCnt}, 32'h2);
        clrLog <= 1'b1;
        @(posedge clk_sys);
        clrLog <= 1'b0;
        tok(6'h10, 32'h0B, GO, `MTEU_RES_ACCEPT);
        repeat (60) @(posedge clk_sys);
        check({24'h0, seenMask}, 32'h0B);
        check({24'h0, stbCnt}, 32'h3);
        check({31'h0, ordOk}, 32'h1);
        tok(6'h10, 32'h10, GO, `MTEU_RES_FUNC);
        tok(6'h10, 32'h01, GO, `MTEU_RES_ACCEPT);
        tok(6'h16, 32'h00010000, GO, `MTEU_RES_REJECT);
        tok(6'h16, {MFRC, 16'h0001}, GO, `MTEU_RES_ACCEPT);
        conclude;
    end
endmodule // tb_meter_token_execution_unit
bind mteu_exec mteu_checker #(.NTEST(NTEST),
    .TEST_SUPPORTED(TEST_SUPPORTED)) chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .resultCode(resultCode),
    .resultPort(resultPort), .resultValid(resultValid),
    .testStrobe(testStrobe), .propStrobe(propStrobe),
    .tamperCancel(tamperCancel), .tamperFlag(tamperFlag));
